// ===== include/dgb_pkg.sv
// Package for the dedicated GPIO bank configuration block: offsets, resets and carrier types.
package dgb_pkg;

  // Register index width and data width of the register port.
  localparam int ADDR_W = 10;
  localparam int DATA_W = 16;

  // Register offsets, as register indices.
  localparam logic [9:0] OFF_FUNC_LO = 10'h3C0;
  localparam logic [9:0] OFF_DIR_LO = 10'h3C1;
  localparam logic [9:0] OFF_SET_LO = 10'h3C2;
  localparam logic [9:0] OFF_CLR_LO = 10'h3C3;
  localparam logic [9:0] OFF_STATE_LO = 10'h3C4;
  localparam logic [9:0] OFF_TRI_LO = 10'h3C5;
  localparam logic [9:0] OFF_DRIVE_MODE_LO = 10'h3C6;
  localparam logic [9:0] OFF_PULLUP_LO = 10'h3C7;
  localparam logic [9:0] OFF_PULLDOWN_LO = 10'h3C8;
  localparam logic [9:0] OFF_IRQ_MASK_LO = 10'h3C9;
  localparam logic [9:0] OFF_RISE_LO = 10'h3CA;
  localparam logic [9:0] OFF_FALL_LO = 10'h3CB;
  localparam logic [9:0] OFF_FUNC_HI = 10'h3CC;
  localparam logic [9:0] OFF_DIR_HI = 10'h3CD;
  localparam logic [9:0] OFF_SET_HI = 10'h3CE;

  // Reset values.
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [15:0] RST_PULLUP = 16'hFFFF;
  localparam logic [15:0] RST_RISE = 16'hFFFF;
  localparam logic [15:0] RST_FALL = 16'hFFFF;

  // One register access request.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [9:0] addr;
    logic [15:0] wdata;
  } dgb_req_s;

  // Per-pin pad controls.
  typedef struct packed {
    logic [31:0] out;
    logic [31:0] oe_n;
    logic [31:0] pu_en;
    logic [31:0] pd_en;
  } dgb_pad_s;

endpackage : dgb_pkg

// ===== src/dgb_bank.sv
// Dedicated GPIO bank: configuration registers, pad control and edge interrupts.
`timescale 1ns/1ps

module dgb_bank (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Register port.
  input wire dgb_pkg::dgb_req_s req,
  output logic [15:0] rdata,
  output logic rvalid,
  // Pins.
  input wire logic [31:0] pin_in,
  output dgb_pkg::dgb_pad_s pad,
  output logic [31:0] dedicated_sel,
  // Pending interrupts, cleared by driving ones on irq_clear.
  input wire logic [31:0] irq_clear,
  output logic [31:0] irq_pending
);

  // Configuration registers; the lower bank has full sets, the upper a subset.
  logic [31:0] func_r;
  logic [31:0] dir_r;
  logic [15:0] tri_r;
  logic [15:0] drive_mode_r;
  logic [15:0] pullup_r;
  logic [15:0] pulldown_r;
  logic [15:0] irq_mask_r;
  logic [15:0] rise_r;
  logic [15:0] fall_r;
  logic [31:0] out_r;
  // Two-stage input synchroniser and previous sample.
  logic [31:0] sync1_r;
  logic [31:0] sync2_r;
  logic [31:0] prev_r;
  // Edge events and pin roles.
  logic [31:0] rise_ev;
  logic [31:0] fall_ev;
  logic [31:0] is_in;
  logic [31:0] is_out;
  logic [15:0] wd;

  assign wd = req.wdata;
  assign is_in = func_r & ~dir_r;
  assign is_out = func_r & dir_r;

  // Write-strobe decode used by many registers.
  function automatic logic hit(input dgb_pkg::dgb_req_s r, input logic [9:0] off);
    hit = r.wr && (r.addr == off);
  endfunction : hit

  // Function select and direction registers for both banks.
  // A pin belongs to this block only while its function-select bit is one; the direction bit
  // then decides whether it is a dedicated input or a dedicated output. Both reset to zero, so
  // after reset every pin is left with the shared function and nothing here drives it.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      func_r <= 32'h00000000;
      dir_r <= 32'h00000000;
    end else begin
      if (hit(req, dgb_pkg::OFF_FUNC_LO)) func_r[15:0] <= wd;
      if (hit(req, dgb_pkg::OFF_FUNC_HI)) func_r[31:16] <= wd;
      if (hit(req, dgb_pkg::OFF_DIR_LO)) dir_r[15:0] <= wd;
      if (hit(req, dgb_pkg::OFF_DIR_HI)) dir_r[31:16] <= wd;
    end
  end

  // Pad option registers of the lower bank.
  // These only store what software wrote; the pad process below decides, pin by pin, whether
  // a stored bit applies, so a pull-up bit of an output pin is kept but has no effect on the pad.
  // The pull-up bits reset to ones so that a pin handed over as an input is never left floating.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tri_r <= dgb_pkg::RST_ZERO;
      drive_mode_r <= dgb_pkg::RST_ZERO;
      pullup_r <= dgb_pkg::RST_PULLUP;
      pulldown_r <= dgb_pkg::RST_ZERO;
    end else begin
      if (hit(req, dgb_pkg::OFF_TRI_LO)) tri_r <= wd;
      if (hit(req, dgb_pkg::OFF_DRIVE_MODE_LO)) drive_mode_r <= wd;
      if (hit(req, dgb_pkg::OFF_PULLUP_LO)) pullup_r <= wd;
      if (hit(req, dgb_pkg::OFF_PULLDOWN_LO)) pulldown_r <= wd;
    end
  end

  // Interrupt enable registers. Edge-enable bits of dedicated output pins are held, so a write
  // aimed at them does nothing; the mask register is stored as written because the edge logic
  // below ignores it for anything that is not a dedicated input.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_mask_r <= dgb_pkg::RST_ZERO;
      rise_r <= dgb_pkg::RST_RISE;
      fall_r <= dgb_pkg::RST_FALL;
    end else begin
      if (hit(req, dgb_pkg::OFF_IRQ_MASK_LO)) irq_mask_r <= wd;
      if (hit(req, dgb_pkg::OFF_RISE_LO)) rise_r <= (wd & ~is_out[15:0]) | (rise_r & is_out[15:0]);
      if (hit(req, dgb_pkg::OFF_FALL_LO)) fall_r <= (wd & ~is_out[15:0]) | (fall_r & is_out[15:0]);
    end
  end

  // Output latch: set, clear and state writes touch output pins only.
  // Only one register index is written per cycle, so set, clear and state never meet here.
  // Bits of input pins keep their old value, which is what a later change of direction
  // will put on the pin; software should set the level before it turns a pin around.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      out_r <= 32'h00000000;
    end else begin
      if (hit(req, dgb_pkg::OFF_SET_LO)) out_r[15:0] <= out_r[15:0] | (wd & is_out[15:0]);
      if (hit(req, dgb_pkg::OFF_SET_HI)) out_r[31:16] <= out_r[31:16] | (wd & is_out[31:16]);
      if (hit(req, dgb_pkg::OFF_CLR_LO)) out_r[15:0] <= out_r[15:0] & ~(wd & is_out[15:0]);
      if (hit(req, dgb_pkg::OFF_STATE_LO)) begin
        out_r[15:0] <= (wd & is_out[15:0]) | (out_r[15:0] & ~is_out[15:0]);
      end
    end
  end

  // Input synchroniser; only the second stage and the previous sample feed edge logic.
  // The first stage may still be settling, so nothing but the second stage reads it.
  // The previous sample is one more stage, which gives an edge detector that compares two
  // settled values; an input change thus becomes visible as an edge one edge after capture.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync1_r <= 32'h00000000;
      sync2_r <= 32'h00000000;
      prev_r <= 32'h00000000;
    end else begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  // Edge qualification: only lower-bank input pins have enable registers here.
  // A pin qualifies when it is a dedicated input, its mask bit is set and the enable for the
  // direction of the change is set; with both enables set every change counts.
  // The upper bank has no mask or edge enables in this block, so its events stay at zero.
  assign rise_ev = {16'h0000, sync2_r[15:0] & ~prev_r[15:0] & rise_r & irq_mask_r & is_in[15:0]};
  assign fall_ev = {16'h0000, ~sync2_r[15:0] & prev_r[15:0] & fall_r & irq_mask_r & is_in[15:0]};

  // Sticky pending bits; a new event wins over a clear in the same cycle.
  // Letting the event win means that an edge arriving while software clears the previous one
  // is never lost; at worst software sees one extra interrupt that it can clear again.
  // Bits are cleared only by the clear input, never by reading or by changing the enables.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_pending <= 32'h00000000;
    end else begin
      irq_pending <= (irq_pending & ~irq_clear) | rise_ev | fall_ev;
    end
  end

  // Read data: state returns pin levels, write-only registers read zero.
  // The data follows the index every cycle and is qualified by the one-cycle valid pulse.
  // The state read shows the synchronised level of dedicated pins, inputs and outputs alike,
  // so an output that an external load holds down reads as low although the latch is high.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata <= 16'h0000;
      rvalid <= 1'b0;
    end else begin
      rvalid <= req.rd;
      unique case (req.addr)
        dgb_pkg::OFF_FUNC_LO: rdata <= func_r[15:0];
        dgb_pkg::OFF_FUNC_HI: rdata <= func_r[31:16];
        dgb_pkg::OFF_DIR_LO: rdata <= dir_r[15:0];
        dgb_pkg::OFF_DIR_HI: rdata <= dir_r[31:16];
        dgb_pkg::OFF_STATE_LO: rdata <= sync2_r[15:0] & func_r[15:0];
        dgb_pkg::OFF_TRI_LO: rdata <= tri_r;
        dgb_pkg::OFF_DRIVE_MODE_LO: rdata <= drive_mode_r;
        dgb_pkg::OFF_PULLUP_LO: rdata <= pullup_r;
        dgb_pkg::OFF_PULLDOWN_LO: rdata <= pulldown_r;
        dgb_pkg::OFF_IRQ_MASK_LO: rdata <= irq_mask_r;
        dgb_pkg::OFF_RISE_LO: rdata <= rise_r;
        dgb_pkg::OFF_FALL_LO: rdata <= fall_r;
        default: rdata <= 16'h0000;
      endcase
    end
  end

  // Pad drive: open-drain drives low only; tri-state releases; pulls as configured.
  // The output enable is active low and is low only while this block drives the pin.
  // An open-drain output at one is released and relies on the weak pull-up, which stays on
  // for it whatever the pull-up register says; input pulls apply to dedicated inputs only.
  // Pads of the upper bank have no tri-state, open-drain or pull control in this block.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pad.out <= 32'h00000000;
      pad.oe_n <= 32'hFFFFFFFF;
      pad.pu_en <= {16'h0000, dgb_pkg::RST_PULLUP};
      pad.pd_en <= 32'h00000000;
      dedicated_sel <= 32'h00000000;
    end else begin
      dedicated_sel <= func_r;
      pad.out <= out_r;
      pad.oe_n[31:16] <= ~is_out[31:16];
      pad.oe_n[15:0] <= ~(is_out[15:0] & ~tri_r & ~(drive_mode_r & out_r[15:0]));
      pad.pu_en[31:16] <= 16'h0000;
      pad.pu_en[15:0] <= (pullup_r & is_in[15:0]) | (drive_mode_r & is_out[15:0]);
      pad.pd_en[31:16] <= 16'h0000;
      pad.pd_en[15:0] <= pulldown_r & is_in[15:0];
    end
  end

  // Assertions and covers. Pin 4 is the dedicated input that is toggled in use, pins 0 and 1
  // are dedicated outputs, pin 16 is an upper-bank output and pin 8 stays with the shared
  // function, so each check below but the synchroniser check on pin 7 watches a pin whose configuration really gets exercised.

  // A qualified rising edge on an unmasked dedicated input must leave a pending bit.
  a_rise_pend: assert property (@(posedge ref_clk) disable iff (rst)
    (is_in[4] && irq_mask_r[4] && rise_r[4] && sync2_r[4] && !prev_r[4]) |=> irq_pending[4])
    else $error("rising edge did not set pending");
  // A qualified falling edge must do the same.
  a_fall_pend: assert property (@(posedge ref_clk) disable iff (rst)
    (is_in[4] && irq_mask_r[4] && fall_r[4] && !sync2_r[4] && prev_r[4]) |=> irq_pending[4])
    else $error("falling edge did not set pending");
  // With the mask bit low an idle pending bit stays idle, whatever the pin does.
  a_mask_gate: assert property (@(posedge ref_clk) disable iff (rst)
    (!irq_mask_r[4] && !irq_pending[4] && !irq_clear[4]) |=> !irq_pending[4])
    else $error("masked pin raised interrupt");
  // A rise on a pin whose rising enable is off raises nothing, even with the mask set.
  a_edge_off: assert property (@(posedge ref_clk) disable iff (rst)
    (!rise_r[4] && sync2_r[4] && !prev_r[4] && !irq_pending[4] && !irq_clear[4]) |=> !irq_pending[4])
    else $error("disabled edge raised interrupt");
  // With both enables set, any change of the synchronised level is an interrupt.
  a_both_edges: assert property (@(posedge ref_clk) disable iff (rst)
    (is_in[4] && irq_mask_r[4] && rise_r[4] && fall_r[4] && sync2_r[4] != prev_r[4]) |=> irq_pending[4])
    else $error("both-edge interrupt missed");
  // A pending bit is sticky until a clear reaches it.
  a_pend_hold: assert property (@(posedge ref_clk) disable iff (rst)
    (irq_pending[4] && !irq_clear[4]) |=> irq_pending[4])
    else $error("pending bit dropped without clear");
  // A clear with no new event in the same cycle empties the bit.
  a_pend_clear: assert property (@(posedge ref_clk) disable iff (rst)
    (irq_clear[4] && !rise_ev[4] && !fall_ev[4]) |=> !irq_pending[4])
    else $error("clear did not empty pending bit");
  // A set write drives a dedicated output to one.
  a_set_drive: assert property (@(posedge ref_clk) disable iff (rst)
    (hit(req, dgb_pkg::OFF_SET_LO) && req.wdata[1] && is_out[1]) |=> out_r[1])
    else $error("set did not drive one");
  // A clear write drives a dedicated output to zero.
  a_clr_drive: assert property (@(posedge ref_clk) disable iff (rst)
    (hit(req, dgb_pkg::OFF_CLR_LO) && req.wdata[0] && is_out[0]) |=> !out_r[0])
    else $error("clear did not drive zero");
  // A state write must not disturb the output latch of an input pin.
  a_state_input: assert property (@(posedge ref_clk) disable iff (rst)
    (hit(req, dgb_pkg::OFF_STATE_LO) && !is_out[4]) |=> out_r[4] == $past(out_r[4]))
    else $error("state write moved an input pin");
  // An edge-enable write aimed at a dedicated output keeps the stored bit.
  a_edge_filter: assert property (@(posedge ref_clk) disable iff (rst)
    (hit(req, dgb_pkg::OFF_RISE_LO) && is_out[0]) |=> rise_r[0] == $past(rise_r[0]))
    else $error("edge enable of output pin changed");
  // A push-pull output that is not tri-stated is driven with its latched level.
  a_push_pull: assert property (@(posedge ref_clk) disable iff (rst)
    (is_out[0] && !drive_mode_r[0] && !tri_r[0]) |=> !pad.oe_n[0] && pad.out[0] == $past(out_r[0]))
    else $error("push-pull output not driven");
  // An open-drain output at one is released, with the weak pull-up holding the line.
  a_od_high: assert property (@(posedge ref_clk) disable iff (rst)
    (is_out[1] && drive_mode_r[1] && out_r[1]) |=> pad.oe_n[1] && pad.pu_en[1])
    else $error("open-drain drove high");
  // A tri-stated pin is never driven.
  a_tri_rel: assert property (@(posedge ref_clk) disable iff (rst)
    tri_r[0] |=> pad.oe_n[0])
    else $error("tri-state pin driven");
  // A dedicated input with its pull-up bit set gets the pull-up.
  a_pu_input: assert property (@(posedge ref_clk) disable iff (rst)
    (is_in[4] && pullup_r[4]) |=> pad.pu_en[4])
    else $error("pull-up missing");
  // A dedicated input with its pull-down bit set gets the pull-down.
  a_pd_input: assert property (@(posedge ref_clk) disable iff (rst)
    (is_in[4] && pulldown_r[4]) |=> pad.pd_en[4])
    else $error("pull-down missing");
  // A pin left with the shared function is neither driven nor pulled by this block.
  a_shared_idle: assert property (@(posedge ref_clk) disable iff (rst)
    !func_r[8] |=> pad.oe_n[8] && !pad.pu_en[8] && !pad.pd_en[8])
    else $error("shared pin touched");
  // A dedicated output of the upper bank is driven.
  a_upper_out: assert property (@(posedge ref_clk) disable iff (rst)
    is_out[16] |=> !pad.oe_n[16])
    else $error("upper output not driven");
  // A rise on the pin reaches the second synchroniser stage two edges later.
  a_sync_path: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(pin_in[7]) |-> ##2 sync2_r[7])
    else $error("sync latency wrong");

  // Covers for the main scenarios: both edge kinds, upper set, state write, open-drain high.
  c_rise: cover property (@(posedge ref_clk) disable iff (rst) rise_ev[4]);
  c_fall: cover property (@(posedge ref_clk) disable iff (rst) fall_ev[4]);
  c_set: cover property (@(posedge ref_clk) disable iff (rst) hit(req, dgb_pkg::OFF_SET_HI));
  c_state_wr: cover property (@(posedge ref_clk) disable iff (rst) hit(req, dgb_pkg::OFF_STATE_LO));
  c_od_high: cover property (@(posedge ref_clk) disable iff (rst) is_out[1] && drive_mode_r[1] && out_r[1]);

endmodule : dgb_bank

// ===== bench/dgb_periph.sv
// Peripheral model on the far side of the bank's pins.
`timescale 1ns/1ps
module dgb_periph (
  // Clock for the floating-line pattern.
  input wire logic ref_clk,
  // Pad controls and peripheral drive.
  input wire dgb_pkg::dgb_pad_s pad,
  input wire logic [31:0] ext_en,
  input wire logic [31:0] ext_val,
  // Resolved pin levels.
  output logic [31:0] pin_level
);
  // Undriven, unpulled lines flip every cycle so no stale value passes.
  logic [31:0] float_r = 32'h5555AAAA;
  always @(posedge ref_clk) begin
    float_r <= ~float_r;
  end

  // Bank drive wins, then the peripheral, then the pulls.
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      if (!pad.oe_n[i]) begin
        pin_level[i] = pad.out[i];
      end else if (ext_en[i]) begin
        pin_level[i] = ext_val[i];
      end else if (pad.pu_en[i]) begin
        pin_level[i] = 1'b1;
      end else if (pad.pd_en[i]) begin
        pin_level[i] = 1'b0;
      end else begin
        pin_level[i] = float_r[i];
      end
    end
  end
endmodule : dgb_periph

// ===== bench/dgb_bank_bench.sv
// Self-checking bench for the dedicated GPIO bank.
`timescale 1ns/1ps
module dgb_bank_bench;
  // Stimulus, outputs and counters.
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  dgb_pkg::dgb_req_s req = '0;
  logic [31:0] irq_clear = '0;
  logic [31:0] ext_en = '0;
  logic [31:0] ext_val = '0;
  logic [15:0] rdata;
  logic rvalid;
  logic [31:0] pin_in;
  dgb_pkg::dgb_pad_s pad;
  logic [31:0] dedicated_sel;
  logic [31:0] irq_pending;
  int error_cnt = 0;
  int check_count = 0;
  int cycles = 0;

  always #5 ref_clk = ~ref_clk;

  dgb_bank dut_u (.ref_clk(ref_clk), .rst(rst), .req(req), .rdata(rdata), .rvalid(rvalid), .pin_in(pin_in),
    .pad(pad), .dedicated_sel(dedicated_sel), .irq_clear(irq_clear), .irq_pending(irq_pending));
  dgb_periph periph_u (.ref_clk(ref_clk), .pad(pad), .ext_en(ext_en), .ext_val(ext_val), .pin_level(pin_in));

  // Compare and count.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Write one register; returns once the pads have settled.
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    @(posedge ref_clk) #1;
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk) #1;
    req.wr = 1'b0;
    @(posedge ref_clk) #1;
  endtask : wr

  // Read one register and compare it in the cycle rvalid stands.
  task automatic rd(input logic [9:0] a, input logic [15:0] exp);
    @(posedge ref_clk) #1;
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge ref_clk) #1;
    req.rd = 1'b0;
    chk({31'h0, rvalid}, 32'h1);
    chk({16'h0, rdata}, {16'h0, exp});
  endtask : rd

  // Move pin 4, wait out the sync delay, check and clear pending.
  task automatic pin_edge(input logic lvl, input logic exp);
    @(posedge ref_clk) #1;
    ext_val[4] = lvl;
    repeat (5) @(posedge ref_clk);
    #1;
    chk({31'h0, irq_pending[4]}, {31'h0, exp});
    irq_clear = 32'hFFFFFFFF;
    @(posedge ref_clk) #1;
    irq_clear = '0;
  endtask : pin_edge

  // Reset values of the table, then an unmapped index.
  task automatic t_reset;
    logic [15:0] exp;
    chk(pad.pu_en, 32'h0000FFFF);
    chk(pad.oe_n, 32'hFFFFFFFF);
    for (int i = 0; i < 8; i++) begin
      exp = (i == 1 || i == 4 || i == 5) ? 16'hFFFF : 16'h0000;
      rd(dgb_pkg::OFF_DRIVE_MODE_LO + 10'(i), exp);
    end
    wr(10'h3FF, 16'hFFFF);
    rd(10'h3FF, 16'h0000);
  endtask : t_reset

  // Pins 0 and 1 as outputs, pin 4 as input.
  task automatic t_outputs;
    wr(dgb_pkg::OFF_FUNC_LO, 16'h0013);
    wr(dgb_pkg::OFF_PULLUP_LO, 16'hFFFC);
    wr(dgb_pkg::OFF_DIR_LO, 16'h0003);
    wr(dgb_pkg::OFF_SET_LO, 16'h0003);
    chk(pad.out & 32'h3, 32'h3);
    chk(pad.oe_n & 32'h3, 32'h0);
    wr(dgb_pkg::OFF_CLR_LO, 16'h0001);
    chk(pad.out & 32'h3, 32'h2);
    wr(dgb_pkg::OFF_DRIVE_MODE_LO, 16'h0002);
    chk(pad.oe_n & 32'h3, 32'h2);
    chk(pad.pu_en & 32'h3, 32'h2);
    repeat (3) @(posedge ref_clk);
    rd(dgb_pkg::OFF_STATE_LO, 16'h0012);
    wr(dgb_pkg::OFF_STATE_LO, 16'h0010);
    chk(pad.out & 32'h13, 32'h0);
    wr(dgb_pkg::OFF_TRI_LO, 16'h0001);
    chk(pad.oe_n & 32'h1, 32'h1);
    // Rising pin 1 is an output, so its mask must not matter.
    wr(dgb_pkg::OFF_IRQ_MASK_LO, 16'h0002);
    wr(dgb_pkg::OFF_SET_LO, 16'h0002);
    repeat (5) @(posedge ref_clk);
    #1;
    chk(irq_pending, 32'h0);
    wr(dgb_pkg::OFF_RISE_LO, 16'h0000);
    rd(dgb_pkg::OFF_RISE_LO, 16'h0003);
  endtask : t_outputs

  // Masking and each edge selection on input pin 4.
  task automatic t_irq;
    ext_val[4] = 1'b1;
    ext_en[4] = 1'b1;
    wr(dgb_pkg::OFF_PULLDOWN_LO, 16'h0011);
    chk(pad.pd_en, 32'h00000010);
    chk(pad.pu_en & 32'h00000013, 32'h00000012);
    pin_edge(1'b0, 1'b0);
    pin_edge(1'b1, 1'b0);
    wr(dgb_pkg::OFF_IRQ_MASK_LO, 16'h0012);
    wr(dgb_pkg::OFF_RISE_LO, 16'h0010);
    wr(dgb_pkg::OFF_FALL_LO, 16'h0000);
    pin_edge(1'b0, 1'b0);
    pin_edge(1'b1, 1'b1);
    wr(dgb_pkg::OFF_RISE_LO, 16'h0000);
    wr(dgb_pkg::OFF_FALL_LO, 16'h0010);
    pin_edge(1'b0, 1'b1);
    pin_edge(1'b1, 1'b0);
    wr(dgb_pkg::OFF_RISE_LO, 16'h0010);
    pin_edge(1'b0, 1'b1);
    pin_edge(1'b1, 1'b1);
  endtask : t_irq

  // Upper bank: only dedicated outputs follow the set register.
  task automatic t_upper;
    wr(dgb_pkg::OFF_FUNC_HI, 16'h0001);
    wr(dgb_pkg::OFF_DIR_HI, 16'h0001);
    wr(dgb_pkg::OFF_SET_HI, 16'h0003);
    chk(dedicated_sel >> 16, 32'h1);
    chk(pad.oe_n >> 16, 32'hFFFE);
    chk(pad.out >> 16, 32'h1);
  endtask : t_upper

  // Counts, verdict and end of run.
  task automatic conclude;
    $display("Checks %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude

  // Hang guard, well above the fewer than two hundred cycles needed.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      conclude();
    end
  end

  // Main sequence after three reset cycles.
  initial begin
    repeat (3) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    t_reset();
    t_outputs();
    t_irq();
    t_upper();
    conclude();
  end
endmodule : dgb_bank_bench
